// ---- design/timer16_mode_capture_control.v ----
// Mode control and capture/compare control of a 16-bit timer.
// Assumes a byte register port, a count tick enable and synchronous pins.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_regs.vh"

module timer16_mode_capture_control #(
  parameter CW = 16
) (
  // Clock, reset, enable
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire          ce_i,
  // Register port
  input  wire [15:0]   addr_i,
  input  wire          wr_en_i,
  input  wire          rd_en_i,
  input  wire [7:0]    wdata_i,
  output reg  [7:0]    rdata_o,
  // Capture/compare register writes
  input  wire          capcmp_a_we_i,
  input  wire          capcmp_b_we_i,
  input  wire [CW-1:0] capcmp_wdata_i,
  // Count clock and edge selects
  input  wire          count_tick_i,
  input  wire [1:0]    edge_sel_a_i,
  input  wire [1:0]    edge_sel_b_i,
  // One-shot control
  input  wire          oneshot_mode_i,
  input  wire          oneshot_sw_trigger_i,
  // Timer pins
  input  wire          timer_in_a_i,
  input  wire          timer_in_b_i,
  output reg           timer_out_pin_o,
  // Status
  output reg  [CW-1:0] count_value_o,
  output reg  [CW-1:0] capcmp_reg_a_o,
  output reg  [CW-1:0] capcmp_reg_b_o,
  output reg           match_irq_a_o,
  output reg           match_irq_b_o
);

  reg  [3:0] timer_mode_reg_q;
  reg  [2:0] capcmp_ctrl_reg_q;
  reg        match_a_q;
  reg        match_b_q;
  reg        ovf_set;
  reg [CW-1:0] count_d;

  // Reset words, trimmed to the stored widths below
  localparam [7:0] MODE_RST = `TIMER_MODE_RESET;
  localparam [7:0] CTRL_RST = `CAPCMP_CTRL_RESET;

  wire       valid_a;
  wire       opp_a;
  wire       valid_b;
  wire       wr_mode;
  wire       wr_ctrl;
  wire [1:0] run_mode;
  wire       running;
  wire       edge_toggle_sel;
  wire       reg_a_capture_sel;
  wire       reg_a_trigger_sel;
  wire       reg_b_capture_sel;
  wire       match_a;
  wire       match_b;
  wire       match_a_ev;
  wire       match_b_ev;
  wire       cap_a;
  wire       cap_b;

  // Edge detectors on both input pins
  timer_pin_edge u_edge_a (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .ce_i         (ce_i),
    .pin_i        (timer_in_a_i),
    .edge_sel_i   (edge_sel_a_i),
    .valid_edge_o (valid_a),
    .opp_edge_o   (opp_a)
  );

  timer_pin_edge u_edge_b (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .ce_i         (ce_i),
    .pin_i        (timer_in_b_i),
    .edge_sel_i   (edge_sel_b_i),
    .valid_edge_o (valid_b),
    .opp_edge_o   ()
  );

  // Address decode
  assign wr_mode = ce_i & wr_en_i & (addr_i == `ADDR_TIMER_MODE);
  assign wr_ctrl = ce_i & wr_en_i & (addr_i == `ADDR_CAPCMP_CTRL);

  // Field views
  assign run_mode          = timer_mode_reg_q[`BIT_MODE_HI:`BIT_MODE_LO];
  assign running           = (run_mode != `MODE_STOP);
  assign edge_toggle_sel   = timer_mode_reg_q[`BIT_EDGE_TOGGLE];
  assign reg_a_capture_sel = capcmp_ctrl_reg_q[`BIT_A_CAPTURE];
  assign reg_a_trigger_sel = capcmp_ctrl_reg_q[`BIT_A_TRIGGER];
  assign reg_b_capture_sel = capcmp_ctrl_reg_q[`BIT_B_CAPTURE];

  // Continuous compare against the count
  assign match_a    = running & ~reg_a_capture_sel &
                      (count_value_o == capcmp_reg_a_o);
  assign match_b    = running & ~reg_b_capture_sel &
                      (count_value_o == capcmp_reg_b_o);
  assign match_a_ev = ce_i & match_a & ~match_a_q;
  assign match_b_ev = ce_i & match_b & ~match_b_q;

  // Capture triggers
  assign cap_a = running & reg_a_capture_sel &
                 (reg_a_trigger_sel ? opp_a : valid_b);
  assign cap_b = running & reg_b_capture_sel & valid_a;

  // Next count and overflow detection
  always @* begin
    count_d = count_value_o;
    ovf_set = 1'b0;
    case (run_mode)
      `MODE_STOP: begin
        count_d = `COUNT_ZERO;
      end
      `MODE_FREE, `MODE_CLR_EDGE, `MODE_CLR_MATCH: begin
        if (run_mode == `MODE_CLR_EDGE && valid_a) begin
          count_d = `COUNT_ZERO;
        end else if (oneshot_mode_i && oneshot_sw_trigger_i) begin
          count_d = `COUNT_ZERO;
        end else if (count_tick_i) begin
          if (run_mode == `MODE_CLR_MATCH &&
              count_value_o == capcmp_reg_a_o &&
              count_value_o != `COUNT_MAX) begin
            count_d = `COUNT_ZERO;
          end else begin
            count_d = count_value_o + {{(CW-1){1'b0}}, 1'b1};
            ovf_set = (count_value_o == `COUNT_MAX);
          end
        end
      end
      default: begin
        count_d = `COUNT_ZERO;
      end
    endcase
  end

  // Control registers
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer_mode_reg_q  <= MODE_RST[3:0];
      capcmp_ctrl_reg_q <= CTRL_RST[2:0];
    end else if (ce_i) begin
      if (wr_mode) begin
        timer_mode_reg_q[3:1] <= wdata_i[3:1];
      end
      if (ovf_set) begin
        timer_mode_reg_q[`BIT_OVERFLOW] <= 1'b1;
      end else if (wr_mode) begin
        timer_mode_reg_q[`BIT_OVERFLOW] <= wdata_i[`BIT_OVERFLOW];
      end
      if (wr_ctrl) begin
        capcmp_ctrl_reg_q <= wdata_i[2:0];
      end
    end
  end

  // Counter, capture/compare registers, output and requests
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_value_o   <= `COUNT_ZERO;
      capcmp_reg_a_o  <= `COUNT_ZERO;
      capcmp_reg_b_o  <= `COUNT_ZERO;
      match_a_q       <= 1'b0;
      match_b_q       <= 1'b0;
      timer_out_pin_o <= 1'b0;
      match_irq_a_o   <= 1'b0;
      match_irq_b_o   <= 1'b0;
    end else if (ce_i) begin
      count_value_o <= count_d;
      match_a_q     <= match_a;
      match_b_q     <= match_b;
      if (cap_a) begin
        capcmp_reg_a_o <= count_value_o;
      end else if (capcmp_a_we_i) begin
        capcmp_reg_a_o <= capcmp_wdata_i;
      end
      if (cap_b) begin
        capcmp_reg_b_o <= count_value_o;
      end else if (capcmp_b_we_i) begin
        capcmp_reg_b_o <= capcmp_wdata_i;
      end
      if (running && (match_a_ev || match_b_ev ||
                      (edge_toggle_sel && valid_a))) begin
        timer_out_pin_o <= ~timer_out_pin_o;
      end
      match_irq_a_o <= match_a_ev | cap_a;
      match_irq_b_o <= match_b_ev | cap_b;
    end else begin
      match_irq_a_o <= 1'b0;
      match_irq_b_o <= 1'b0;
    end
  end

  // Register read path, unmapped reads zero
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i && rd_en_i) begin
      if (addr_i == `ADDR_TIMER_MODE) begin
        rdata_o <= {4'h0, timer_mode_reg_q};
      end else if (addr_i == `ADDR_CAPCMP_CTRL) begin
        rdata_o <= {5'h00, capcmp_ctrl_reg_q};
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/timer16_regs.vh ----
// Register offsets, field positions and reset values of the timer block.
// Assumes the including file supplies all logic; definitions only.
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH

`define ADDR_TIMER_MODE    16'hffba
`define ADDR_CAPCMP_CTRL   16'hffbc

`define TIMER_MODE_RESET   8'h00
`define CAPCMP_CTRL_RESET  8'h00

// Timer mode register fields
`define BIT_OVERFLOW       0
`define BIT_EDGE_TOGGLE    1
`define BIT_MODE_LO        2
`define BIT_MODE_HI        3

// Capture/compare control fields
`define BIT_A_CAPTURE      0
`define BIT_A_TRIGGER      1
`define BIT_B_CAPTURE      2

// Run mode encodings
`define MODE_STOP          2'b00
`define MODE_FREE          2'b01
`define MODE_CLR_EDGE      2'b10
`define MODE_CLR_MATCH     2'b11

// Valid edge selections
`define EDGE_FALL          2'b00
`define EDGE_RISE          2'b01
`define EDGE_BOTH          2'b11

`define COUNT_MAX          16'hffff
`define COUNT_ZERO         16'h0000

`endif

// ---- design/timer_pin_edge.v ----
// Valid edge detector for one timer input pin.
// Assumes the pin is synchronous to clk_i and the edge select is static.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_regs.vh"

module timer_pin_edge (
  // Clock, reset and enable
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  // Pin and edge select
  input  wire       pin_i,
  input  wire [1:0] edge_sel_i,
  // Detected events
  output wire       valid_edge_o,
  output wire       opp_edge_o
);

  reg  pin_q;
  wire rise;
  wire fall;

  // Previous pin level
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b0;
    end else if (ce_i) begin
      pin_q <= pin_i;
    end
  end

  assign rise = ce_i & pin_i & ~pin_q;
  assign fall = ce_i & ~pin_i & pin_q;

  // Selected edge and its opposite phase
  assign valid_edge_o = (edge_sel_i == `EDGE_RISE) ? rise :
                        (edge_sel_i == `EDGE_FALL) ? fall :
                        (edge_sel_i == `EDGE_BOTH) ? (rise | fall) : 1'b0;
  assign opp_edge_o   = (edge_sel_i == `EDGE_RISE) ? fall :
                        (edge_sel_i == `EDGE_FALL) ? rise : 1'b0;

endmodule
`default_nettype wire

// ---- verif/pulse_src.sv ----
// Model of the external pulse sources on the two timer input pins.
// Assumes the bench calls its task just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module pulse_src (
  input  wire logic clk_i,
  output var  logic pin_a_o,
  output var  logic pin_b_o
);
  initial begin
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end
  // High then low, each level held four count clocks
  task automatic pulse(input bit on_b);
    repeat (2) begin
      @(posedge clk_i) #1;
      if (on_b) pin_b_o = !pin_b_o;
      else pin_a_o = !pin_a_o;
      repeat (3) @(posedge clk_i);
    end
    #1; // Hand back off the clock edge
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the timer mode and capture control block.
// Assumes a 50 MHz clock and the pulse source model on the pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0;
  logic cwa = 1'b0, cwb = 1'b0, osm = 1'b0, ost = 1'b0, o0;
  logic [15:0] addr_i = 16'h0, cwd = 16'h0, r0;
  logic [7:0] wdata_i = 8'h0, rdata_o;
  logic [1:0] esa = 2'b01, esb = 2'b01;
  logic ce = 1'b1, tick = 1'b1;
  logic pa, pb, out, ia, ib;
  logic [15:0] cnt, ra, rb;
  int fails = 0, tests_run = 0, cyc = 0;
  initial forever #10 clk_i = !clk_i;
  timer16_mode_capture_control uut (.clk_i, .rst_n_i, .ce_i(ce),
    .addr_i, .wr_en_i, .rd_en_i, .wdata_i, .rdata_o, .capcmp_a_we_i(cwa),
    .capcmp_b_we_i(cwb), .capcmp_wdata_i(cwd), .count_tick_i(tick),
    .edge_sel_a_i(esa), .edge_sel_b_i(esb), .oneshot_mode_i(osm),
    .oneshot_sw_trigger_i(ost), .timer_in_a_i(pa), .timer_in_b_i(pb),
    .timer_out_pin_o(out), .count_value_o(cnt), .capcmp_reg_a_o(ra),
    .capcmp_reg_b_o(rb), .match_irq_a_o(ia), .match_irq_b_o(ib));
  pulse_src src (.clk_i, .pin_a_o(pa), .pin_b_o(pb));
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    step();
    wr_en_i = 1'b0;
    step(); // Strobe rests a cycle between writes
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    addr_i = a;
    rd_en_i = 1'b1;
    step();
    rd_en_i = 1'b0;
    chk(rdata_o, e);
    step(); // Strobe rests a cycle between reads
  endtask
  task automatic setcc(input logic [15:0] a, b);
    cwd = a;
    cwa = 1'b1;
    step();
    cwa = 1'b0;
    cwd = b;
    cwb = 1'b1;
    step();
    cwb = 1'b0;
  endtask
  task automatic wait_irq(input bit on_b, input int lim);
    for (int i = 0; i < lim && !(on_b ? ib : ia); i++) step();
    chk(on_b ? ib : ia, 1'b1);
  endtask
  task automatic t_regs();
    rd(16'hffba, 8'h00);
    rd(16'hffbc, 8'h00);
    wr(16'hffbc, 8'hff);
    rd(16'hffbc, 8'h07);
    rd(16'hffbe, 8'h00);
    wr(16'hffba, 8'hf6);
    rd(16'hffba, 8'h06);
    wr(16'hffba, 8'h00);
    wr(16'hffbc, 8'h00);
    chk(cnt, 16'h0);
  endtask
  task automatic t_free();
    setcc(16'hffff, 16'h0005);
    o0 = out;
    wr(16'hffba, 8'h04);
    wait_irq(1, 10);
    chk(cnt, 16'h0006);
    chk(out, !o0);
    for (int i = 0; i < 70000 && cnt !== 16'hffff; i++) step();
    step(2);
    rd(16'hffba, 8'h05);
    wr(16'hffba, 8'h00);
    step();
    chk(cnt, 16'h0);
    rd(16'hffba, 8'h00);
  endtask
  task automatic t_edge();
    setcc(16'hffff, 16'hffff);
    wr(16'hffba, 8'h0a);
    step(20);
    o0 = out;
    src.pulse(0);
    step();
    chk(cnt < 16'd10, 1'b1);
    chk(out, !o0);
    wr(16'hffba, 8'h00);
  endtask
  task automatic t_cap();
    wr(16'hffbc, 8'h05);
    wr(16'hffba, 8'h04);
    step(30);
    esb = 2'b00;
    fork src.pulse(1); wait_irq(0, 8); join
    chk(ra - 16'd34 < 16'd4, 1'b1);
    fork src.pulse(0); wait_irq(1, 6); join
    chk(rb - ra, 16'h0004);
    wr(16'hffba, 8'h00);
    wr(16'hffbc, 8'h03);
    wr(16'hffba, 8'h04);
    r0 = ra;
    fork src.pulse(0); begin step(4); chk(ra, r0); end join
    chk(ra !== r0, 1'b1);
    wr(16'hffba, 8'h00);
    esa = 2'b11;
    wr(16'hffba, 8'h04);
    r0 = ra;
    src.pulse(0);
    step();
    chk(ra, r0);
    wr(16'hffba, 8'h00);
  endtask
  task automatic t_match();
    wr(16'hffbc, 8'h00);
    setcc(16'h0003, 16'hffff);
    o0 = out;
    wr(16'hffba, 8'h0c);
    wait_irq(0, 8);
    chk(cnt, 16'h0000);
    chk(out, !o0);
    step();
    wait_irq(0, 8);
    chk(cnt, 16'h0000);
    chk(out, o0);
    rd(16'hffba, 8'h0c);
    wr(16'hffba, 8'h00);
  endtask
  task automatic t_hold();
    logic [15:0] c0;
    wr(16'hffba, 8'h04);
    step(5);
    c0 = cnt;
    ce = 1'b0;
    step(4);
    chk(cnt, c0);
    ce = 1'b1;
    tick = 1'b0;
    step(3);
    chk(cnt, c0);
    tick = 1'b1;
    step();
    chk(cnt, c0 + 16'd1);
    wr(16'hffba, 8'h00);
  endtask
  task automatic t_one();
    osm = 1'b1;
    wr(16'hffba, 8'h04);
    step(20);
    ost = 1'b1;
    step();
    ost = 1'b0;
    step();
    chk(cnt, 16'h0001);
    osm = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    step(16);
    rst_n_i = 1'b1;
    t_regs();
    t_free();
    t_edge();
    t_cap();
    t_match();
    t_hold();
    t_one();
    report_and_stop();
  end
  // Hang guard
  always @(posedge clk_i) if (++cyc > 80000) begin
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- verif/timer16_chk.sv ----
// Checker for the timer mode and capture control block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module timer16_chk #(parameter CW = 16) (
  input wire logic clk_i, rst_n_i, ce_i, wr_en_i, rd_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o,
  input wire logic capcmp_a_we_i, count_tick_i, timer_in_a_i,
  input wire logic [1:0] edge_sel_a_i,
  input wire logic oneshot_mode_i, timer_out_pin_o,
  input wire logic match_irq_a_o, match_irq_b_o,
  input wire logic [CW-1:0] count_value_o, capcmp_reg_a_o, capcmp_reg_b_o
);
  logic [3:1] mode_q;
  logic [2:0] ctl_q;
  wire run = mode_q[3:2] != 2'b00;
  wire eq_b = count_value_o == capcmp_reg_b_o;
  wire wr = ce_i && wr_en_i;
  wire rd = ce_i && rd_en_i && !wr_en_i;
  // Shadow of the written control bits
  always @(posedge clk_i)
    if (!rst_n_i) begin
      mode_q <= 3'h0;
      ctl_q <= 3'h0;
    end else if (wr && addr_i == 16'hffba) mode_q <= wdata_i[3:1];
    else if (wr && addr_i == 16'hffbc) ctl_q <= wdata_i[2:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_stop_zero: assert property (ce_i && !run |=> count_value_o == 0)
    else $error("count not zero while stopped");
  a_count_step: assert property (ce_i && count_tick_i && !wr_en_i &&
    mode_q[3:2] == 2'b01 && !oneshot_mode_i
    |=> count_value_o == $past(count_value_o) + 1'b1)
    else $error("count did not step");
  a_out_stop: assert property (!run |=> $stable(timer_out_pin_o))
    else $error("output moved while stopped");
  a_match_toggle: assert property (run && !mode_q[1] &&
    ((match_irq_a_o && !ctl_q[0]) ^ (match_irq_b_o && !ctl_q[2]))
    |-> timer_out_pin_o != $past(timer_out_pin_o))
    else $error("output did not toggle on match");
  a_match_b: assert property (ce_i && run && !ctl_q[2] && eq_b &&
    !$past(eq_b) |=> !ce_i || match_irq_b_o)
    else $error("no match request");
  a_capture_b: assert property (ce_i && run && ctl_q[2] &&
    edge_sel_a_i == 2'b01 && $rose(timer_in_a_i)
    |-> ##[1:4] match_irq_b_o)
    else $error("no capture request");
  a_no_capture: assert property (ctl_q[1:0] == 2'b11 &&
    edge_sel_a_i == 2'b11 && !capcmp_a_we_i
    |=> $stable(capcmp_reg_a_o))
    else $error("capture with both edges");
  a_rd_unmapped: assert property (rd && addr_i != 16'hffba &&
    addr_i != 16'hffbc |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rd_ctl: assert property (rd && addr_i == 16'hffbc
    |=> rdata_o == {5'h00, ctl_q})
    else $error("control readback wrong");
  a_rd_mode: assert property (rd && addr_i == 16'hffba
    |=> rdata_o[7:1] == {4'h0, mode_q})
    else $error("mode readback wrong");
  c_match: cover property (match_irq_b_o && !ctl_q[2]);
  c_cap_a: cover property (match_irq_a_o && ctl_q[0]);
  c_wrap: cover property (run && count_value_o == 16'hffff);
  c_clr_match: cover property (mode_q[3:2] == 2'b11 && match_irq_a_o);
endmodule
bind timer16_mode_capture_control timer16_chk #(.CW(CW)) chk (.*);
`default_nettype wire
